// ===== core/oma_pkg.sv
// constants for the on-chip memory indirect access block
package oma_pkg;
    localparam int REG_AW = 8;
    localparam int DAT_W = 8;
    localparam int ADDR_W = 12;
    localparam int NVM_AW = 9;
    localparam int ROM_AW = 12;
    localparam int NVM_DEPTH = 512;
    localparam int ROM_DEPTH = 4096;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h8B;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h8C;
    localparam logic [7:0] OFS_EEPROM_PORT = 8'h8D;
    localparam logic [7:0] OFS_SRAM_PORT = 8'h8E;
    localparam logic [7:0] OFS_ROM_PORT = 8'h8F;
    localparam int HIGH_MSB = 3;
    localparam logic [3:0] RST_ADDR_HIGH = 4'h0;
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RSVD_HIGH = 8'h00;
    typedef enum logic [1:0] {
        OMA_PORT_NONE,
        OMA_PORT_EEPROM,
        OMA_PORT_SRAM,
        OMA_PORT_ROM
    } oma_port_t;
endpackage

// ===== core/oma_sram.sv
// shadow sram: one write port, registered read
`timescale 1ns/10ps
module oma_sram
    import oma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [NVM_AW-1:0] i_addr,
    input wire logic [DAT_W-1:0] i_wdata,
    output logic [DAT_W-1:0] o_rdata
);
    logic [DAT_W-1:0] mem [NVM_DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// ===== core/oma_burst_ptr.sv
// burst pointer: loads on first access, counts on later ones
`timescale 1ns/10ps
module oma_burst_ptr
    import oma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic i_step,
    input wire logic [ADDR_W-1:0] i_start,
    output logic [ADDR_W-1:0] o_ptr
);
    logic [ADDR_W-1:0] next_ptr;

    always_comb begin
        next_ptr = o_ptr;
        if (i_load) begin
            next_ptr = i_start;
        end else if (i_step) begin
            next_ptr = o_ptr + ADDR_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ptr <= '0;
        end else begin
            o_ptr <= next_ptr;
        end
    end
endmodule

// ===== core/oma_top.sv
// indirect access from the register space into eeprom, shadow sram and rom
// Operation
// - address high register holds start bits 11:8 in [3:0], resets zero
// - address low register holds start bits 7:0, writable, resets zero
// - eeprom and sram use start bits 8:0; rom uses 11:0
// - first eeprom port read returns byte at the programmed start address
// - each further eeprom port read advances address and returns next byte
// - after first eeprom port access the register pointer stops incrementing
// - eeprom burst ends with the transaction; next starts at start address
// - first sram port access reads or writes the start address
// - further sram port accesses advance address and act on next location
// - after first sram port access the pointer stays locked on it
// - sram burst ends when the transaction terminates
// - rom port behaves alike: start byte, advancing, pointer locked
// - eeprom unreadable while programming; host waits for busy to clear
`timescale 1ns/10ps
module oma_top
    import oma_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_REG_RD,
    input wire logic I_REG_WR,
    input wire logic [REG_AW-1:0] I_REG_ADDR,
    input wire logic [DAT_W-1:0] I_REG_WDATA,
    input wire logic I_XFER_END,
    input wire logic I_NVM_PROGRAM_IN_PROGRESS,
    input wire logic [DAT_W-1:0] I_EEPROM_RDATA,
    input wire logic [DAT_W-1:0] I_ROM_RDATA,
    output logic [DAT_W-1:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    output logic O_PTR_HOLD,
    output logic [NVM_AW-1:0] O_EEPROM_ADDR,
    output logic [ROM_AW-1:0] O_ROM_ADDR
);
    logic [3:0] addr_high;
    logic [7:0] addr_low;
    logic [3:0] next_addr_high;
    logic [7:0] next_addr_low;
    oma_port_t lock;
    oma_port_t next_lock;
    oma_port_t acc_port;
    logic acc;
    logic first;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] cur;
    logic sram_we;
    logic [DAT_W-1:0] sram_rdata;
    logic rd_pend;
    oma_port_t rd_port;
    logic [REG_AW-1:0] rd_addr;
    logic [DAT_W-1:0] next_rdata;

    assign start = {addr_high, addr_low};

    always_comb begin
        acc_port = OMA_PORT_NONE;
        unique case (I_REG_ADDR)
            OFS_EEPROM_PORT: acc_port = OMA_PORT_EEPROM;
            OFS_SRAM_PORT: acc_port = OMA_PORT_SRAM;
            OFS_ROM_PORT: acc_port = OMA_PORT_ROM;
            default: acc_port = OMA_PORT_NONE;
        endcase
    end

    // a locked transaction sends every access to the locked port
    assign acc = (I_REG_RD || I_REG_WR) && (lock != OMA_PORT_NONE || acc_port != OMA_PORT_NONE);
    assign first = acc && (lock == OMA_PORT_NONE);
    assign cur = first ? start : ptr + ADDR_W'(1);

    assign O_PTR_HOLD = (lock != OMA_PORT_NONE) || (acc_port != OMA_PORT_NONE);

    always_comb begin
        next_addr_high = addr_high;
        next_addr_low = addr_low;
        next_lock = lock;
        if (I_REG_WR && lock == OMA_PORT_NONE && I_REG_ADDR == OFS_ADDR_HIGH) begin
            next_addr_high = I_REG_WDATA[HIGH_MSB:0];
        end
        if (I_REG_WR && lock == OMA_PORT_NONE && I_REG_ADDR == OFS_ADDR_LOW) begin
            next_addr_low = I_REG_WDATA;
        end
        if (first) begin
            next_lock = acc_port;
        end
        if (I_XFER_END) begin
            next_lock = OMA_PORT_NONE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            addr_high <= RST_ADDR_HIGH;
            addr_low <= RST_ADDR_LOW;
            lock <= OMA_PORT_NONE;
        end else begin
            addr_high <= next_addr_high;
            addr_low <= next_addr_low;
            lock <= next_lock;
        end
    end

    oma_burst_ptr u_ptr (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_load(first),
        .i_step(acc && !first),
        .i_start(start),
        .o_ptr(ptr)
    );

    oma_port_t eff_port;
    assign eff_port = (lock == OMA_PORT_NONE) ? acc_port : lock;

    assign sram_we = acc && I_REG_WR && eff_port == OMA_PORT_SRAM;

    oma_sram u_sram (
        .i_clk(I_CLK),
        .i_we(sram_we),
        .i_addr(cur[NVM_AW-1:0]),
        .i_wdata(I_REG_WDATA),
        .o_rdata(sram_rdata)
    );

    logic [NVM_AW-1:0] next_eeprom_addr;
    logic [ROM_AW-1:0] next_rom_addr;
    assign next_eeprom_addr = (acc && eff_port == OMA_PORT_EEPROM) ? cur[NVM_AW-1:0]
                                                                     : O_EEPROM_ADDR;
    assign next_rom_addr = (acc && eff_port == OMA_PORT_ROM) ? cur : O_ROM_ADDR;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_EEPROM_ADDR <= '0;
            O_ROM_ADDR <= '0;
            rd_pend <= 1'b0;
            rd_port <= OMA_PORT_NONE;
            rd_addr <= '0;
        end else begin
            O_EEPROM_ADDR <= next_eeprom_addr;
            O_ROM_ADDR <= next_rom_addr;
            rd_pend <= I_REG_RD;
            rd_port <= eff_port;
            rd_addr <= I_REG_ADDR;
        end
    end

    always_comb begin
        next_rdata = RST_DATA;
        unique case (rd_port)
            OMA_PORT_EEPROM: next_rdata = I_NVM_PROGRAM_IN_PROGRESS ? RST_DATA : I_EEPROM_RDATA;
            OMA_PORT_SRAM: next_rdata = sram_rdata;
            OMA_PORT_ROM: next_rdata = I_ROM_RDATA;
            OMA_PORT_NONE: begin
                if (rd_addr == OFS_ADDR_HIGH) begin
                    next_rdata = RSVD_HIGH | {4'h0, addr_high};
                end else if (rd_addr == OFS_ADDR_LOW) begin
                    next_rdata = addr_low;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_REG_RDATA <= RST_DATA;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RDATA <= rd_pend ? next_rdata : O_REG_RDATA;
            O_REG_RVALID <= rd_pend;
        end
    end

    a_start_stable: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (acc && !I_REG_WR) |=> $stable(start))
        else $error("start address moved during burst");
    a_lock_first: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (first && !I_XFER_END && acc_port == OMA_PORT_EEPROM) |=> lock == OMA_PORT_EEPROM)
        else $error("eeprom port not locked");
    a_lock_sram: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (first && !I_XFER_END && acc_port == OMA_PORT_SRAM) |=> O_PTR_HOLD)
        else $error("sram port not held");
    a_end_unlock: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_XFER_END |=> lock == OMA_PORT_NONE)
        else $error("burst survived end");
    a_end_sram: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_XFER_END && lock == OMA_PORT_SRAM) |=> !(lock == OMA_PORT_SRAM))
        else $error("sram burst survived end");
    a_first_eeprom: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (first && acc_port == OMA_PORT_EEPROM) |=> O_EEPROM_ADDR == $past(start[NVM_AW-1:0]))
        else $error("eeprom first address wrong");
    a_next_eeprom: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (acc && !first && lock == OMA_PORT_EEPROM)
        |=> O_EEPROM_ADDR == $past(O_EEPROM_ADDR) + NVM_AW'(1))
        else $error("eeprom address did not advance");
    a_rom_next: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (acc && !first && lock == OMA_PORT_ROM) |=> O_ROM_ADDR == $past(O_ROM_ADDR) + ROM_AW'(1))
        else $error("rom address did not advance");
    a_high_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_REG_WR && lock == OMA_PORT_NONE && I_REG_ADDR == OFS_ADDR_HIGH)
        |=> addr_high == $past(I_REG_WDATA[HIGH_MSB:0]))
        else $error("high address not written");

    a_low_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_REG_WR && lock == OMA_PORT_NONE && I_REG_ADDR == OFS_ADDR_LOW)
        |=> addr_low == $past(I_REG_WDATA))
        else $error("low address not written");

    a_high_rsvd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_pend && rd_port == OMA_PORT_NONE && rd_addr == OFS_ADDR_HIGH)
        |=> O_REG_RDATA[DAT_W-1:HIGH_MSB+1] == '0)
        else $error("reserved high bits not zero");

    a_locked_start: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_REG_WR && lock != OMA_PORT_NONE) |=> $stable(start))
        else $error("start address written while locked");

    a_hold_locked: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (lock != OMA_PORT_NONE) |-> O_PTR_HOLD)
        else $error("pointer not held while locked");

    a_sram_first: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (first && I_REG_WR && acc_port == OMA_PORT_SRAM) |-> (sram_we && cur == start))
        else $error("sram first write misplaced");

    a_sram_next: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (acc && !first && lock == OMA_PORT_SRAM) |=> ptr == $past(ptr) + ADDR_W'(1))
        else $error("sram address did not advance");

    a_rom_first: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (first && acc_port == OMA_PORT_ROM) |=> O_ROM_ADDR == $past(start))
        else $error("rom first address wrong");

    a_ptr_load: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        first |=> ptr == $past(start))
        else $error("burst pointer not loaded");

    a_eeprom_data: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_pend && rd_port == OMA_PORT_EEPROM && !I_NVM_PROGRAM_IN_PROGRESS)
        |=> O_REG_RDATA == $past(I_EEPROM_RDATA))
        else $error("eeprom data not returned");

    a_busy_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_pend && rd_port == OMA_PORT_EEPROM && I_NVM_PROGRAM_IN_PROGRESS)
        |=> O_REG_RDATA == RST_DATA)
        else $error("eeprom data leaked while busy");

    a_sram_data: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_pend && rd_port == OMA_PORT_SRAM) |=> O_REG_RDATA == $past(sram_rdata))
        else $error("sram data not returned");

    a_rom_data: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_pend && rd_port == OMA_PORT_ROM) |=> O_REG_RDATA == $past(I_ROM_RDATA))
        else $error("rom data not returned");

    a_rvalid_lat: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_REG_RD |-> ##2 O_REG_RVALID)
        else $error("read answer late");

    a_rvalid_only: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !I_REG_RD |-> ##2 !O_REG_RVALID)
        else $error("read answer without read");

    a_rdata_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !rd_pend |=> $stable(O_REG_RDATA))
        else $error("read data changed without read");

    a_wr_ignored: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_REG_WR && eff_port != OMA_PORT_SRAM) |-> !sram_we)
        else $error("write reached sram from another port");

    a_end_rom: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_XFER_END && lock == OMA_PORT_ROM) |=> lock != OMA_PORT_ROM)
        else $error("rom burst survived end");
endmodule

// ===== sim/oma_host.sv
// host model: register transactions as an i2c slave front end issues them
`timescale 1ns/10ps
module oma_host
    import oma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_hold,
    input wire logic i_rvalid,
    input wire logic [DAT_W-1:0] i_rdata,
    output logic o_rd,
    output logic o_wr,
    output logic o_end,
    output logic [REG_AW-1:0] o_addr,
    output logic [DAT_W-1:0] o_wdata
);
    logic [DAT_W-1:0] wbuf [0:15];
    logic [DAT_W-1:0] rbuf [$];
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_end = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    always @(posedge i_clk) begin
        if (i_rvalid === 1'b1) begin
            rbuf.push_back(i_rdata);
        end
    end
    // n bytes; gap idle cycles between bytes models a slow bus
    task automatic xfer(input logic w, input logic [REG_AW-1:0] a, input int n, input int gap);
        logic [REG_AW-1:0] ptr;
        ptr = a;
        rbuf.delete();
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            // pointer moves only while not held
            if (i > 0 && i_hold !== 1'b1) begin
                ptr = ptr + 8'h01;
            end
            o_rd <= !w;
            o_wr <= w;
            o_addr <= ptr;
            o_wdata <= wbuf[i];
            o_end <= (i == n - 1);
            if (gap > 0 && i < n - 1) begin
                @(posedge i_clk);
                o_rd <= 1'b0;
                o_wr <= 1'b0;
                repeat (gap - 1) @(posedge i_clk);
            end
        end
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_end <= 1'b0;
        // released lines carry garbage, not the last value
        o_addr <= ~o_addr;
        o_wdata <= ~o_wdata;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// ===== sim/oma_tb_top.sv
// self-checking bench for the memory indirect access block
`timescale 1ns/10ps
module oma_tb_top
    import oma_pkg::*;
;
    logic clk, rst, rd, wr, xend, busy, rvalid, hold;
    logic [7:0] addr, wdata, erd, rrd, rdata;
    logic [8:0] eaddr;
    logic [11:0] raddr, s;
    logic [31:0] seed = 32'h00006E27;
    logic [31:0] r;
    logic [7:0] exp [0:7];
    int miscompares = 0;
    int comparisons = 0;
    int k, gap;
    function automatic logic [7:0] ef(input logic [8:0] a);
        return a[7:0] ^ {7'h2D, a[8]};
    endfunction
    function automatic logic [7:0] rf(input logic [11:0] a);
        return a[7:0] + {a[11:8], a[11:8]} + 8'h11;
    endfunction
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // busy array shows garbage so a leak is visible
    assign erd = busy ? ~ef(eaddr) : ef(eaddr);
    assign rrd = rf(raddr);
    oma_top oma_top_i (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_RD(rd), .I_REG_WR(wr),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_XFER_END(xend),
        .I_NVM_PROGRAM_IN_PROGRESS(busy), .I_EEPROM_RDATA(erd), .I_ROM_RDATA(rrd),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_PTR_HOLD(hold),
        .O_EEPROM_ADDR(eaddr), .O_ROM_ADDR(raddr));
    oma_host oma_host_i (.i_clk(clk), .i_hold(hold), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_rd(rd), .o_wr(wr), .o_end(xend), .o_addr(addr), .o_wdata(wdata));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp(input string nm, input int n);
        for (int i = 0; i < n; i++) begin
            chk(nm, exp[i], oma_host_i.rbuf[i]);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        rst = 1'b1;
        busy = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        exp[0] = 8'h00;
        exp[1] = 8'h00;
        oma_host_i.xfer(1'b0, OFS_ADDR_HIGH, 2, 0);
        cmp("reset address", 2);
        $display("reset test done");
        for (int t = 0; t < 6; t++) begin
            r = xs();
            // first trial sits on the top address to force wrap
            s = (t == 0) ? 12'hFFF : r[11:0];
            k = 2 + int'(r[15:14]);
            gap = int'(r[17:16]);
            oma_host_i.wbuf[0] = {r[23:20], s[11:8]};
            oma_host_i.wbuf[1] = s[7:0];
            oma_host_i.xfer(1'b1, OFS_ADDR_HIGH, 2, gap);
            exp[0] = {4'h0, s[11:8]};
            exp[1] = s[7:0];
            for (int i = 0; i < k; i++) begin
                exp[i + 2] = ef(s[8:0] + 9'(i));
            end
            oma_host_i.xfer(1'b0, OFS_ADDR_HIGH, k + 2, gap);
            cmp("eeprom by increment", k + 2);
            exp[0] = ef(s[8:0]);
            exp[1] = ef(s[8:0] + 9'h001);
            oma_host_i.xfer(1'b0, OFS_EEPROM_PORT, 2, gap);
            cmp("eeprom restart", 2);
            for (int i = 0; i < k; i++) begin
                r = xs();
                oma_host_i.wbuf[i] = r[7:0];
                exp[i] = r[7:0];
            end
            oma_host_i.xfer(1'b1, OFS_SRAM_PORT, k, gap);
            oma_host_i.xfer(1'b0, OFS_SRAM_PORT, k, gap);
            cmp("sram burst", k);
            for (int i = 0; i < k; i++) begin
                exp[i] = rf(s + 12'(i));
            end
            oma_host_i.xfer(1'b0, OFS_ROM_PORT, k, gap);
            cmp("rom burst", k);
            $display("trial %0d done", t);
        end
        busy <= 1'b1;
        exp[0] = 8'h00;
        oma_host_i.xfer(1'b0, OFS_EEPROM_PORT, 1, 0);
        cmp("busy eeprom", 1);
        busy <= 1'b0;
        exp[0] = ef(s[8:0]);
        oma_host_i.xfer(1'b0, OFS_EEPROM_PORT, 1, 0);
        cmp("eeprom after busy", 1);
        $display("busy test done");
        test_done();
    end
endmodule
